// file: src/dswc_pkg.sv
package dswc_pkg;
   // ==========================================================
   // Widths
   localparam int VAL_W   = 32;
   localparam int DLY_W   = 20;
   localparam int TC_W    = 4;
   localparam int SCL_W   = 16;
   localparam int MON_W   = 16;
   localparam int NUM_OUT = 4;
   localparam int NUM_MON = 2;

   // ==========================================================
   // Constants
   // Scale factor is signed fixed point with this many fraction bits
   localparam int MON_SH = 12;
   localparam logic signed [MON_W-1:0] MON_POS_FS = 16'h7FFF;
   localparam logic signed [MON_W-1:0] MON_NEG_FS = 16'h8001;
   localparam logic [DLY_W-1:0] DLY_ZERO = 20'h00000;
   localparam logic [DLY_W-1:0] DLY_ONE  = 20'h00001;
   localparam logic [DLY_W-1:0] DLY_MAX  = 20'hFFFFF;
   localparam logic signed [VAL_W-1:0] VAL_ZERO = 32'h00000000;
   localparam logic signed [MON_W-1:0] MON_ZERO = 16'h0000;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      DSWC_FN_OFF,
      DSWC_FN_ON,
      DSWC_FN_TORQUE,
      DSWC_FN_SPEED,
      DSWC_FN_TARGET,
      DSWC_FN_FOLLOW
   } dswc_fn_t;

   typedef enum logic [3:0] {
      DSWC_SRC_SPD_SET,
      DSWC_SRC_SPD_ACT,
      DSWC_SRC_POS_SET,
      DSWC_SRC_POS_ACT,
      DSWC_SRC_IQ_SET,
      DSWC_SRC_IQ_ACT,
      DSWC_SRC_ID_SET,
      DSWC_SRC_ID_ACT,
      DSWC_SRC_PHASE_I,
      DSWC_SRC_ROTOR,
      DSWC_SRC_FREE
   } dswc_src_t;

   typedef struct packed {
      logic signed [VAL_W-1:0] spd_set;
      logic signed [VAL_W-1:0] spd_act;
      logic signed [VAL_W-1:0] pos_set;
      logic signed [VAL_W-1:0] pos_act;
      logic signed [VAL_W-1:0] iq_set;
      logic signed [VAL_W-1:0] iq_act;
      logic signed [VAL_W-1:0] id_set;
      logic signed [VAL_W-1:0] id_act;
      logic signed [VAL_W-1:0] phase_i;
      logic signed [VAL_W-1:0] rotor;
      logic signed [VAL_W-1:0] free_obj;
   } dswc_proc_t;

   typedef struct packed {
      logic signed [VAL_W-1:0] cmp_current;
      logic signed [VAL_W-1:0] current_win;
      logic [TC_W-1:0]         tc_shift;
      logic signed [VAL_W-1:0] cmp_speed;
      logic signed [VAL_W-1:0] speed_win;
      logic signed [VAL_W-1:0] speed_thr;
      logic [DLY_W-1:0]        speed_dly;
      logic signed [VAL_W-1:0] target_pos;
      logic signed [VAL_W-1:0] tgt_neg_tol;
      logic signed [VAL_W-1:0] tgt_pos_tol;
      logic [DLY_W-1:0]        target_dly;
      logic signed [VAL_W-1:0] fol_neg_tol;
      logic signed [VAL_W-1:0] fol_pos_tol;
      logic [DLY_W-1:0]        follow_dly;
   } dswc_cfg_t;

   typedef struct packed {
      dswc_src_t               src;
      logic signed [SCL_W-1:0] scale;
      logic                    limit_en;
   } dswc_mon_cfg_t;
endpackage

// file: src/dswc_status.sv
`timescale 1ns/1ps
`default_nettype none
module dswc_status
   import dswc_pkg::*;
(
   // Clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    sys_rst_i,
   // Process values and configuration
   input  wire dswc_proc_t              proc_i,
   input  wire dswc_cfg_t               cfg_i,
   input  wire dswc_fn_t                dout_sel_i [NUM_OUT],
   input  wire dswc_mon_cfg_t           mon_cfg_i [NUM_MON],
   // Status flags and filtered current
   output logic                         torque_reached_o,
   output logic                         speed_reached_o,
   output logic                         target_reached_o,
   output logic                         following_error_o,
   output logic                         speed_above_thr_o,
   output logic signed [VAL_W-1:0]      current_filt_o,
   // Pins
   output logic [NUM_OUT-1:0]           dout_o,
   output logic signed [MON_W-1:0]      analogue_monitor_a_o,
   output logic signed [MON_W-1:0]      analogue_monitor_b_o
);

   // ==========================================================
   // Functions
   // Widened so that extreme centres and tolerances cannot overflow
   function automatic logic in_win(input logic signed [VAL_W-1:0] x,
                                   input logic signed [VAL_W-1:0] c,
                                   input logic signed [VAL_W-1:0] neg,
                                   input logic signed [VAL_W-1:0] pos);
      logic signed [VAL_W+1:0] lo;
      logic signed [VAL_W+1:0] hi;
      lo = (VAL_W+2)'(c) - (VAL_W+2)'(neg);
      hi = (VAL_W+2)'(c) + (VAL_W+2)'(pos);
      return ((VAL_W+2)'(x) >= lo) && ((VAL_W+2)'(x) <= hi);
   endfunction

   function automatic logic [DLY_W-1:0] dwell_cnt(input logic cond,
                                                  input logic [DLY_W-1:0] cnt);
      if (!cond) begin
         return DLY_ZERO;
      end
      return (cnt == DLY_MAX) ? cnt : cnt + DLY_ONE;
   endfunction

   function automatic logic signed [MON_W-1:0] scale_out(
      input logic signed [VAL_W-1:0] v,
      input logic signed [SCL_W-1:0] k,
      input logic                    lim);
      logic signed [VAL_W+SCL_W-1:0] p;
      p = (v * k) >>> MON_SH;
      if (lim && p > (VAL_W+SCL_W)'(MON_POS_FS)) begin
         return MON_POS_FS;
      end
      if (lim && p < (VAL_W+SCL_W)'(MON_NEG_FS)) begin
         return MON_NEG_FS;
      end
      return p[MON_W-1:0];
   endfunction

   function automatic logic signed [VAL_W-1:0] pick(input dswc_proc_t p,
                                                    input dswc_src_t s);
      unique case (s)
         DSWC_SRC_SPD_SET: return p.spd_set;
         DSWC_SRC_SPD_ACT: return p.spd_act;
         DSWC_SRC_POS_SET: return p.pos_set;
         DSWC_SRC_POS_ACT: return p.pos_act;
         DSWC_SRC_IQ_SET:  return p.iq_set;
         DSWC_SRC_IQ_ACT:  return p.iq_act;
         DSWC_SRC_ID_SET:  return p.id_set;
         DSWC_SRC_ID_ACT:  return p.id_act;
         DSWC_SRC_PHASE_I: return p.phase_i;
         DSWC_SRC_ROTOR:   return p.rotor;
         DSWC_SRC_FREE:    return p.free_obj;
         default:          return VAL_ZERO;
      endcase
   endfunction

   // ==========================================================
   // Current filter
   logic signed [VAL_W-1:0] filt_ff;
   logic signed [VAL_W-1:0] nxt_filt;
   logic signed [VAL_W:0]   filt_diff;

   always_comb begin
      // Shift form keeps the filter multiplier free; tc is a power of two
      filt_diff = (VAL_W+1)'(proc_i.iq_act) - (VAL_W+1)'(filt_ff);
      nxt_filt  = filt_ff + VAL_W'(filt_diff >>> cfg_i.tc_shift);
   end

   // ==========================================================
   // Window comparators and dwell timers
   logic             tq_in;
   logic             spd_in;
   logic             tgt_in;
   logic             fol_in;
   logic [DLY_W-1:0] spd_cnt_ff;
   logic [DLY_W-1:0] tgt_cnt_ff;
   logic [DLY_W-1:0] fol_cnt_ff;
   logic [DLY_W-1:0] nxt_spd_cnt;
   logic [DLY_W-1:0] nxt_tgt_cnt;
   logic [DLY_W-1:0] nxt_fol_cnt;
   logic             tq_ff;
   logic             spd_ff;
   logic             tgt_ff;
   logic             fol_ff;
   logic             thr_ff;
   logic             nxt_tq;
   logic             nxt_spd;
   logic             nxt_tgt;
   logic             nxt_fol;
   logic             nxt_thr;

   always_comb begin
      tq_in  = in_win(filt_ff, cfg_i.cmp_current, cfg_i.current_win,
                      cfg_i.current_win);
      spd_in = in_win(proc_i.spd_act, cfg_i.cmp_speed, cfg_i.speed_win,
                      cfg_i.speed_win);
      tgt_in = in_win(proc_i.pos_act, cfg_i.target_pos, cfg_i.tgt_neg_tol,
                      cfg_i.tgt_pos_tol);
      // Outside means error; the count runs while the position is away
      fol_in = !in_win(proc_i.pos_act, proc_i.pos_set, cfg_i.fol_neg_tol,
                       cfg_i.fol_pos_tol);
      nxt_spd_cnt = dwell_cnt(spd_in, spd_cnt_ff);
      nxt_tgt_cnt = dwell_cnt(tgt_in, tgt_cnt_ff);
      nxt_fol_cnt = dwell_cnt(fol_in, fol_cnt_ff);
      nxt_tq  = tq_in;
      nxt_spd = spd_in && (spd_cnt_ff >= cfg_i.speed_dly);
      // Count keeps running while inside, so a new target that still
      // encloses the position does not restart the dwell
      nxt_tgt = tgt_in && (tgt_ff || tgt_cnt_ff >= cfg_i.target_dly);
      nxt_fol = fol_in && (fol_cnt_ff >= cfg_i.follow_dly);
      nxt_thr = proc_i.spd_act >= cfg_i.speed_thr;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         filt_ff    <= VAL_ZERO;
         spd_cnt_ff <= DLY_ZERO;
         tgt_cnt_ff <= DLY_ZERO;
         fol_cnt_ff <= DLY_ZERO;
         tq_ff      <= 1'b0;
         spd_ff     <= 1'b0;
         tgt_ff     <= 1'b0;
         fol_ff     <= 1'b0;
         thr_ff     <= 1'b0;
      end else begin
         filt_ff    <= nxt_filt;
         spd_cnt_ff <= nxt_spd_cnt;
         tgt_cnt_ff <= nxt_tgt_cnt;
         fol_cnt_ff <= nxt_fol_cnt;
         tq_ff      <= nxt_tq;
         spd_ff     <= nxt_spd;
         tgt_ff     <= nxt_tgt;
         fol_ff     <= nxt_fol;
         thr_ff     <= nxt_thr;
      end
   end

   // ==========================================================
   // Digital outputs and analogue monitors
   // The following error only goes to following_error_o and the pins; nothing here acts
   // on the power stage, shutdown lives elsewhere.
   logic [NUM_OUT-1:0]      dout_ff;
   logic [NUM_OUT-1:0]      nxt_dout;
   logic signed [MON_W-1:0] mon_ff [NUM_MON];
   logic signed [MON_W-1:0] nxt_mon [NUM_MON];

   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         unique case (dout_sel_i[i])
            DSWC_FN_OFF:    nxt_dout[i] = 1'b0;
            DSWC_FN_ON:     nxt_dout[i] = 1'b1;
            DSWC_FN_TORQUE: nxt_dout[i] = tq_ff;
            DSWC_FN_SPEED:  nxt_dout[i] = spd_ff;
            DSWC_FN_TARGET: nxt_dout[i] = tgt_ff;
            DSWC_FN_FOLLOW: nxt_dout[i] = fol_ff;
            default:        nxt_dout[i] = 1'b0;
         endcase
      end
      for (int m = 0; m < NUM_MON; m++) begin
         nxt_mon[m] = scale_out(pick(proc_i, mon_cfg_i[m].src),
                                mon_cfg_i[m].scale,
                                mon_cfg_i[m].limit_en);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         dout_ff <= '0;
         for (int m = 0; m < NUM_MON; m++) begin
            mon_ff[m] <= MON_ZERO;
         end
      end else begin
         dout_ff <= nxt_dout;
         for (int m = 0; m < NUM_MON; m++) begin
            mon_ff[m] <= nxt_mon[m];
         end
      end
   end

   always_comb begin
      torque_reached_o     = tq_ff;
      speed_reached_o      = spd_ff;
      target_reached_o     = tgt_ff;
      following_error_o    = fol_ff;
      speed_above_thr_o    = thr_ff;
      current_filt_o       = filt_ff;
      dout_o               = dout_ff;
      analogue_monitor_a_o = mon_ff[0];
      analogue_monitor_b_o = mon_ff[1];
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Own copy of the torque window, so the check does not lean on in_win
   logic tq_chk_lo;
   logic tq_chk_hi;
   always_comb begin
      tq_chk_lo = (VAL_W+2)'(filt_ff) >=
                  (VAL_W+2)'(cfg_i.cmp_current) - (VAL_W+2)'(cfg_i.current_win);
      tq_chk_hi = (VAL_W+2)'(filt_ff) <=
                  (VAL_W+2)'(cfg_i.cmp_current) + (VAL_W+2)'(cfg_i.current_win);
   end

   sequence s_spd_rise;
      !spd_ff ##1 spd_ff;
   endsequence

   sequence s_tgt_rise;
      !tgt_ff ##1 tgt_ff;
   endsequence

   sequence s_fol_rise;
      !fol_ff ##1 fol_ff;
   endsequence

   chk_torque_window: assert property (tq_ff |-> $past(tq_chk_lo && tq_chk_hi))
      else $error("torque flag set outside window");
   chk_torque_clear: assert property (!(tq_chk_lo && tq_chk_hi) |=> !tq_ff)
      else $error("torque flag kept outside window");
   chk_filter_bypass: assert property ((cfg_i.tc_shift == '0) |=>
      filt_ff == $past(proc_i.iq_act))
      else $error("filter with zero constant did not track");
   chk_speed_dwell: assert property (s_spd_rise |->
      $past(spd_cnt_ff) >= $past(cfg_i.speed_dly))
      else $error("speed flag rose before delay");
   chk_speed_drop: assert property (!spd_in |=> !spd_ff && spd_cnt_ff == '0)
      else $error("speed flag or timer not cleared on exit");
   chk_target_dwell: assert property (s_tgt_rise |->
      $past(tgt_cnt_ff) >= $past(cfg_i.target_dly))
      else $error("target flag rose before delay");
   chk_target_hold: assert property (tgt_ff && tgt_in |=> tgt_ff)
      else $error("target flag dropped inside window");
   // No release delay: leaving the window drops the flag at the next edge
   chk_target_drop: assert property (!tgt_in |=> !tgt_ff)
      else $error("target flag kept outside window");
   chk_follow_clear: assert property (!fol_in |=> !fol_ff)
      else $error("following error kept inside window");
   // The message flag waits out the same kind of dwell as the speed and target flags
   chk_follow_dwell: assert property (s_fol_rise |->
      $past(fol_cnt_ff) >= $past(cfg_i.follow_dly))
      else $error("following error rose before delay");
   chk_dout_off: assert property ((dout_sel_i[0] == DSWC_FN_OFF) |=> !dout_o[0])
      else $error("output zero not off");
   // A pin set to the message shows the flag only; nothing else hangs on it
   chk_dout_follow: assert property ((dout_sel_i[1] == DSWC_FN_FOLLOW) |=>
      dout_o[1] == $past(fol_ff))
      else $error("output one does not follow the message flag");
   // Guarded on reset so the first cycle after release is not judged on reset values
   chk_thr_status: assert property (!$past(sys_rst_i) |->
      speed_above_thr_o == $past(proc_i.spd_act >= cfg_i.speed_thr))
      else $error("speed threshold status wrong");
   // Code 8000 lies below the negative bound 8001, so a limited monitor never shows it
   chk_mon_sat: assert property (mon_cfg_i[0].limit_en |=>
      analogue_monitor_a_o != 16'h8000)
      else $error("monitor left limited range");
endmodule
`default_nettype wire

// file: testbench/dswc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dswc_ctrl_model
   import dswc_pkg::*;
(
   // Clock and reset
   input  wire logic               mclk_i,
   input  wire logic               sys_rst_i,
   // Drive pins as the controller sees them
   input  wire logic [NUM_OUT-1:0] dout_i,
   output logic [NUM_OUT-1:0]      seen_o
);
   // ==========================================================
   // Input register
   // A real controller samples its inputs a cycle late, so the bench must too
   logic [NUM_OUT-1:0] seen_ff;
   logic [NUM_OUT-1:0] nxt_seen_ff;
   always_comb begin
      nxt_seen_ff = sys_rst_i ? '0 : dout_i;
   end
   always_ff @(posedge mclk_i) begin
      seen_ff <= nxt_seen_ff;
   end
   assign seen_o = seen_ff;
endmodule
`default_nettype wire

// file: testbench/dswc_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dswc_status_tb_top
   import dswc_pkg::*;
;
   // ==========================================================
   // Signals
   logic                    mclk_i;
   logic                    sys_rst_i;
   dswc_proc_t              proc;
   dswc_cfg_t               cfg;
   dswc_fn_t                dsel [NUM_OUT];
   dswc_mon_cfg_t           mcfg [NUM_MON];
   logic                    torque_reached, speed_reached, target_reached;
   logic                    following_error, speed_above_thr;
   logic signed [VAL_W-1:0] current_filt;
   logic [NUM_OUT-1:0]      dout, seen;
   logic signed [MON_W-1:0] mon_a, mon_b;
   int                      failures, checks, cyc, n;

   dswc_status dswc_status_i (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .proc_i(proc), .cfg_i(cfg),
      .dout_sel_i(dsel), .mon_cfg_i(mcfg), .torque_reached_o(torque_reached),
      .speed_reached_o(speed_reached), .target_reached_o(target_reached),
      .following_error_o(following_error), .speed_above_thr_o(speed_above_thr),
      .current_filt_o(current_filt), .dout_o(dout),
      .analogue_monitor_a_o(mon_a), .analogue_monitor_b_o(mon_b));
   dswc_ctrl_model dswc_ctrl_model_i (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .dout_i(dout), .seen_o(seen));

   // ==========================================================
   // Helpers
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic wrap_up;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Whole run needs about 86 cycles; the ceiling leaves wide margin
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         wrap_up;
      end
   end
   task automatic cmp_val(input logic [VAL_W-1:0] sv, input logic [VAL_W-1:0] ev,
                          input string msg);
      checks++;
      if (sv !== ev) begin
         failures++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, sv, ev);
      end
   endtask
   task automatic negs(input int k);
      repeat (k) @(negedge mclk_i);
   endtask
   function automatic logic flg(input int w);
      case (w)
         0: return speed_reached;
         1: return target_reached;
         default: return following_error;
      endcase
   endfunction
   // Counts falling edges from the driving edge until the flag shows
   task automatic wait_rise(input int w, output int k);
      k = 0;
      do begin
         @(negedge mclk_i);
         k++;
      end while (flg(w) !== 1'b1 && k < 40);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_filter;
      @(posedge mclk_i);
      cfg.tc_shift <= 4'h1;
      proc.iq_act <= 32'h400;
      negs(2);
      cmp_val(current_filt, 32'h200, "filter first step");
      negs(1);
      cmp_val(current_filt, 32'h300, "filter second step");
      @(posedge mclk_i);
      cfg.tc_shift <= 4'h0;
      cfg.cmp_current <= 32'h100;
      cfg.current_win <= 32'h8;
      proc.iq_act <= 32'h108;
      negs(4);
      cmp_val(torque_reached, 1'b1, "torque at upper bound");
      @(posedge mclk_i);
      proc.iq_act <= 32'h109;
      negs(4);
      cmp_val(torque_reached, 1'b0, "torque above window");
      $display("test filter and torque done");
   endtask
   task automatic t_speed;
      @(posedge mclk_i);
      cfg.cmp_speed <= 32'h100;
      cfg.speed_win <= 32'h10;
      cfg.speed_dly <= 20'h00005;
      cfg.speed_thr <= 32'h100;
      proc.spd_act <= 32'h0;
      negs(3);
      cmp_val(speed_reached, 1'b0, "speed outside");
      @(posedge mclk_i);
      proc.spd_act <= 32'h110;
      negs(2);
      cmp_val(speed_above_thr, 1'b1, "threshold");
      @(posedge mclk_i);
      proc.spd_act <= 32'h111;
      @(posedge mclk_i);
      proc.spd_act <= 32'hF0;
      wait_rise(0, n);
      cmp_val(n >= 6 && n <= 8, 1'b1, "speed delay after re-entry");
      cmp_val(speed_above_thr, 1'b0, "below threshold");
      @(posedge mclk_i);
      proc.spd_act <= 32'h111;
      negs(2);
      cmp_val(speed_reached, 1'b0, "speed drop");
      $display("test speed done");
   endtask
   task automatic t_target;
      @(posedge mclk_i);
      cfg.target_pos <= 32'h400;
      cfg.tgt_neg_tol <= 32'h10;
      cfg.tgt_pos_tol <= 32'h40;
      cfg.target_dly <= 20'h00002;
      proc.pos_act <= 32'h800;
      negs(3);
      cmp_val(target_reached, 1'b0, "target far");
      @(posedge mclk_i);
      proc.pos_act <= 32'h3F0;
      wait_rise(1, n);
      cmp_val(n >= 3 && n <= 5, 1'b1, "target delay");
      @(posedge mclk_i);
      cfg.target_pos <= 32'h3E0;
      for (int i = 0; i < 4; i++) begin
         negs(1);
         cmp_val(target_reached, 1'b1, "target kept on new run");
      end
      @(posedge mclk_i);
      proc.pos_act <= 32'h421;
      negs(2);
      cmp_val(target_reached, 1'b0, "target left");
      $display("test target done");
   endtask
   task automatic t_follow;
      @(posedge mclk_i);
      cfg.fol_neg_tol <= 32'h20;
      cfg.fol_pos_tol <= 32'h20;
      cfg.follow_dly <= 20'h00002;
      proc.pos_set <= 32'h420;
      negs(3);
      cmp_val(following_error, 1'b0, "follow inside");
      @(posedge mclk_i);
      proc.pos_act <= 32'h441;
      wait_rise(2, n);
      cmp_val(n >= 3 && n <= 5, 1'b1, "follow delay");
      @(posedge mclk_i);
      proc.pos_act <= 32'h400;
      negs(2);
      cmp_val(following_error, 1'b0, "follow clear");
      $display("test following error done");
   endtask
   task automatic dcase(input dswc_fn_t f0, input dswc_fn_t f1, input dswc_fn_t f2,
                        input dswc_fn_t f3, input logic [NUM_OUT-1:0] e);
      @(posedge mclk_i);
      dsel <= '{f0, f1, f2, f3};
      negs(4);
      cmp_val(seen, e, "digital outputs");
   endtask
   task automatic t_dout;
      @(posedge mclk_i);
      proc.iq_act <= 32'h100;
      negs(2);
      dcase(DSWC_FN_OFF, DSWC_FN_ON, DSWC_FN_TORQUE, DSWC_FN_TARGET, 4'hE);
      dcase(DSWC_FN_SPEED, DSWC_FN_FOLLOW, DSWC_FN_OFF, DSWC_FN_ON, 4'h8);
      dcase(dswc_fn_t'(4'hF), dswc_fn_t'(4'hF), dswc_fn_t'(4'hF),
            dswc_fn_t'(4'hF), 4'h0);
      $display("test digital outputs done");
   endtask
   task automatic mcase(input logic [VAL_W-1:0] v, input logic [SCL_W-1:0] k,
                        input logic l, input logic [MON_W-1:0] e);
      @(posedge mclk_i);
      proc.spd_act <= v;
      mcfg[0] <= '{DSWC_SRC_SPD_ACT, k, l};
      negs(2);
      cmp_val($unsigned(mon_a), e, "monitor a");
   endtask
   task automatic t_mon;
      mcase(32'h64, 16'h1000, 1'b1, 16'h0064);
      mcase(32'h5000, 16'h2000, 1'b1, 16'h7FFF);
      mcase(32'hFFFFB000, 16'h2000, 1'b1, 16'h8001);
      mcase(32'h5000, 16'h2000, 1'b0, 16'hA000);
      @(posedge mclk_i);
      proc.free_obj <= 32'h7;
      mcfg[1] <= '{DSWC_SRC_FREE, 16'h1000, 1'b1};
      negs(2);
      cmp_val($unsigned(mon_b), 16'h0007, "monitor b free object");
      @(posedge mclk_i);
      mcfg[1].src <= dswc_src_t'(4'hF);
      negs(2);
      cmp_val($unsigned(mon_b), 16'h0000, "monitor b bad source");
      $display("test monitors done");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      failures = 0;
      checks = 0;
      cyc = 0;
      sys_rst_i = 1'b1;
      proc = '0;
      cfg = '0;
      dsel = '{default: DSWC_FN_OFF};
      mcfg = '{default: '0};
      repeat (11) @(posedge mclk_i);
      @(negedge mclk_i);
      cmp_val(dout, 4'h0, "dout in reset");
      cmp_val(current_filt, 32'h0, "filter in reset");
      @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      t_filter;
      t_speed;
      t_target;
      t_follow;
      t_dout;
      t_mon;
      wrap_up;
   end
endmodule
`default_nettype wire
